// ### rtl/adc_seq.sv
// Conversion and calibration sequencer with serial port and register slave
//
// Summary of operation
// [R1] Conversion ends and result is delivered after exactly 18 master clock periods.
// [R2] Full self-calibration lasts 125013 master clock periods, about 31.25 ms.
// [R3] DAC plus system full-scale calibration lasts 111114 master clock periods.
// [R4] System offset calibration lasts 13899 master clock periods.
// [R5] Busy rises within 2.5 master periods after calibrate request or trigger fall.
// [R6] Trigger falling edge raises busy, showing a conversion is under way.
// [R7] Modes 4 and 5 drive shift clock out at master clock rate.
// [R8] Modes 1 to 3 take an external shift clock no faster than 4 MHz.
// [R9] Polarity pin low swaps every rising and falling shift-clock edge.
// [R10] Serial output is driven only between frame-select fall and rise.
// [R11] Shared input line turns to output after a shift-clock rising edge.
// [R12] A later rising edge returns it to input; host drives only afterwards.
// [R13] Trigger rising edge puts track-and-hold in hold and starts conversion.
// [R14] Host allows 400 ns acquisition between busy fall and next trigger rise.
// [R15] Software command in the control register can start a conversion.
// [R16] Busy stays high for the whole sequence and drops when it completes.
//
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
module adc_seq #(
	parameter logic [16:0] CAL_FULL_PERIODS   = adc_seq_pkg::CAL_FULL_DEF,
	parameter logic [16:0] CAL_DAC_FS_PERIODS = adc_seq_pkg::CAL_DAC_FS_DEF,
	parameter logic [16:0] CAL_OFFSET_PERIODS = adc_seq_pkg::CAL_OFFSET_DEF
) (
	input  wire logic                              aclk,
	input  wire logic                              aresetn,
	input  wire logic [adc_seq_pkg::ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic                              s_axi_awvalid,
	output logic                                   s_axi_awready,
	input  wire logic [adc_seq_pkg::DATA_W-1:0]    s_axi_wdata,
	input  wire logic [3:0]                        s_axi_wstrb,
	input  wire logic                              s_axi_wvalid,
	output logic                                   s_axi_wready,
	output logic [1:0]                             s_axi_bresp,
	output logic                                   s_axi_bvalid,
	input  wire logic                              s_axi_bready,
	input  wire logic [adc_seq_pkg::ADDR_W-1:0]    s_axi_araddr,
	input  wire logic                              s_axi_arvalid,
	output logic                                   s_axi_arready,
	output logic [adc_seq_pkg::DATA_W-1:0]         s_axi_rdata,
	output logic [1:0]                             s_axi_rresp,
	output logic                                   s_axi_rvalid,
	input  wire logic                              s_axi_rready,
	input  wire logic                              master_clock_input,
	input  wire logic                              conversion_trigger,
	input  wire logic                              cal_request,
	input  wire logic                              polarity,
	input  wire logic                              frame_select_n,
	input  wire logic [adc_seq_pkg::RES_W-1:0]     sample_value,
	input  wire logic                              shift_clock_i,
	output logic                                   shift_clock_o,
	output logic                                   shift_clock_oe,
	input  wire logic                              data_in_i,
	output logic                                   data_in_o,
	output logic                                   data_in_oe,
	output logic                                   data_out_o,
	output logic                                   data_out_oe,
	output logic                                   busy
);
	import adc_seq_pkg::*;

	function automatic logic edge_of(input logic now, input logic was, input logic up);
		edge_of = up ? (now & ~was) : (~now & was);
	endfunction

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	// Two stages per pin, a third stage only for edge finding
	logic [6:0] sync_a, sync_b, sync_c;
	// Result pins settle long before a conversion ends, so two plain stages suffice
	logic [RES_W-1:0] sample_a, sample_b;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_a <= 7'h7f;
			sync_b <= 7'h7f;
			sync_c <= 7'h7f;
			sample_a <= '0;
			sample_b <= '0;
		end else begin
			sample_a <= sample_value;
			sample_b <= sample_a;
			sync_a <= {data_in_i, shift_clock_i, frame_select_n, polarity,
				cal_request, conversion_trigger, master_clock_input};
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end

	logic mclk_rise, mclk_fall, trig_fall, trig_rise, cal_rise;
	logic frame_on, frame_start, frame_end, pol_high;
	assign mclk_rise   = edge_of(sync_b[0], sync_c[0], 1'b1);
	assign mclk_fall   = edge_of(sync_b[0], sync_c[0], 1'b0);
	assign trig_fall   = edge_of(sync_b[1], sync_c[1], 1'b0);
	assign trig_rise   = edge_of(sync_b[1], sync_c[1], 1'b1);
	assign cal_rise    = edge_of(sync_b[2], sync_c[2], 1'b1);
	assign pol_high    = sync_b[3];
	assign frame_on    = ~sync_b[4];
	assign frame_start = edge_of(sync_b[4], sync_c[4], 1'b0);
	assign frame_end   = edge_of(sync_b[4], sync_c[4], 1'b1);

	// ---------------------------------------------------------------
	// Register slave
	// ---------------------------------------------------------------
	logic [ADDR_W-1:0] aw_addr, next_aw_addr;
	logic [DATA_W-1:0] w_data, next_w_data;
	logic              aw_held, next_aw_held, w_held, next_w_held;
	logic              next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0]        next_bresp, next_rresp;
	logic [DATA_W-1:0] next_rdata;
	logic [2:0]        mode, next_mode;
	logic [1:0]        cal_kind, next_cal_kind;
	logic              readback_en, next_readback_en;
	logic              conv_cmd, cal_cmd, do_write, do_read, valid_clr;
	logic              result_valid, next_result_valid;
	logic [RES_W-1:0]  result, next_result;
	logic [WORD_W-1:0] rx_word, next_rx_word;
	seq_state_t        state, next_state;

	assign do_write  = aw_held && w_held && !s_axi_bvalid;
	assign do_read   = s_axi_arvalid && s_axi_arready;
	assign conv_cmd  = do_write && aw_addr == OFF_CONTROL && s_axi_wstrb[0] && w_data[CTL_CONV_BIT];
	assign cal_cmd   = do_write && aw_addr == OFF_CONTROL && s_axi_wstrb[0] && w_data[CTL_CAL_BIT];
	assign valid_clr = do_write && aw_addr == OFF_STATUS && s_axi_wstrb[0] && w_data[ST_VALID_BIT];

	// Address and data are caught separately, so either may come first
	always_comb begin
		next_aw_addr     = aw_addr;
		next_w_data      = w_data;
		next_aw_held     = aw_held;
		next_w_held      = w_held;
		next_bvalid      = s_axi_bvalid && !s_axi_bready;
		next_bresp       = s_axi_bresp;
		next_mode        = mode;
		next_cal_kind    = cal_kind;
		next_readback_en = readback_en;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_addr = s_axi_awaddr;
			next_aw_held = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_data = s_axi_wdata;
			next_w_held = 1'b1;
		end
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = (aw_addr == OFF_CONTROL || aw_addr == OFF_STATUS) ? RESP_OKAY : RESP_SLVERR;
			if (aw_addr == OFF_CONTROL && s_axi_wstrb[0]) begin
				next_mode        = w_data[CTL_MODE_LSB +: 3];
				next_cal_kind    = w_data[CTL_KIND_LSB +: 2];
				next_readback_en = w_data[CTL_READBACK];
			end
		end
		next_awready = !next_aw_held;
		next_wready  = !next_w_held;
	end

	// Reads answer one cycle after the address is taken
	always_comb begin
		next_arready = !(s_axi_rvalid || do_read) || (s_axi_rvalid && s_axi_rready);
		next_rvalid  = (s_axi_rvalid && !s_axi_rready) || do_read;
		next_rdata   = s_axi_rdata;
		next_rresp   = s_axi_rresp;
		if (do_read) begin
			next_rresp = RESP_OKAY;
			next_rdata = '0;
			case (s_axi_araddr)
				OFF_CONTROL: next_rdata = {24'h000000, readback_en, mode, 1'b0, cal_kind, 1'b0};
				OFF_STATUS:  next_rdata = {29'h00000000, result_valid, state == SEQ_CALIB, busy};
				OFF_RESULT:  next_rdata = {20'h00000, result};
				OFF_RX_WORD: next_rdata = {16'h0000, rx_word};
				default:     next_rresp = RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_addr       <= '0;
			w_data        <= '0;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
			mode          <= MODE_RESET;
			cal_kind      <= CAL_FULL;
			readback_en   <= 1'b0;
		end else begin
			aw_addr       <= next_aw_addr;
			w_data        <= next_w_data;
			aw_held       <= next_aw_held;
			w_held        <= next_w_held;
			s_axi_awready <= next_awready;
			s_axi_wready  <= next_wready;
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
			mode          <= next_mode;
			cal_kind      <= next_cal_kind;
			readback_en   <= next_readback_en;
		end
	end

	// ---------------------------------------------------------------
	// Conversion and calibration sequencer
	// ---------------------------------------------------------------
	logic [CNT_W-1:0] count, next_count, target, next_target;
	logic             next_busy, seq_done;
	assign seq_done = mclk_rise && count == target - 17'h00001;

	// When idle, calibration has priority over a conversion request in the same cycle
	always_comb begin
		next_state        = state;
		next_count        = count;
		next_target       = target;
		next_result       = result;
		next_result_valid = result_valid && !valid_clr;
		case (state)
			SEQ_IDLE: begin
				next_count = '0;
				if (cal_rise || cal_cmd) begin
					next_state = SEQ_CALIB;                                // R5
					case (cal_kind)
						CAL_DAC_FS: next_target = CAL_DAC_FS_PERIODS;  // R3
						CAL_OFFSET: next_target = CAL_OFFSET_PERIODS;  // R4
						default:    next_target = CAL_FULL_PERIODS;    // R2
					endcase
				end else if (trig_fall) begin
					next_state = SEQ_ARMED;                                // R6
				end else if (trig_rise || conv_cmd) begin
					next_state  = SEQ_CONVERT;                             // R13 R15
					next_target = CONV_PERIODS;
				end
			end
			SEQ_ARMED: begin
				if (trig_rise) begin
					next_state  = SEQ_CONVERT;                             // R13
					next_target = CONV_PERIODS;
				end
			end
			SEQ_CONVERT, SEQ_CALIB: begin
				if (seq_done) begin
					next_state = SEQ_IDLE;                                 // R16
					if (state == SEQ_CONVERT) begin
						next_result       = sample_b;                  // R1
						next_result_valid = 1'b1;
					end
				end else if (mclk_rise) begin
					next_count = count + 17'h00001;                        // R1 R2 R3 R4
				end
			end
			default: next_state = SEQ_IDLE;
		endcase
		next_busy = next_state != SEQ_IDLE;                                    // R16
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state        <= SEQ_IDLE;
			count        <= '0;
			target       <= CONV_PERIODS;
			result       <= '0;
			result_valid <= 1'b0;
			busy         <= 1'b0;
		end else begin
			state        <= next_state;
			count        <= next_count;
			target       <= next_target;
			result       <= next_result;
			result_valid <= next_result_valid;
			busy         <= next_busy;
		end
	end

	// ---------------------------------------------------------------
	// Serial port
	// ---------------------------------------------------------------
	logic              self_clock, sclk_up, sclk_down, act_rise, act_fall;
	logic [WORD_W-1:0] tx_shift, next_tx_shift, rx_shift, next_rx_shift;
	logic [4:0]        rise_count, next_rise_count;
	logic              next_sclk_o, next_sclk_oe, next_dout_o, next_dout_oe, next_din_o, next_din_oe;

	assign self_clock = mode == MODE_SELF_A || mode == MODE_SELF_B;
	assign sclk_up    = self_clock ? mclk_rise : edge_of(sync_b[5], sync_c[5], 1'b1);
	assign sclk_down  = self_clock ? mclk_fall : edge_of(sync_b[5], sync_c[5], 1'b0);
	assign act_rise   = pol_high ? sclk_up : sclk_down;                        // R9
	assign act_fall   = pol_high ? sclk_down : sclk_up;                        // R9

	// Data changes on the active falling edge and is sampled on the rising one
	always_comb begin
		next_sclk_oe    = self_clock;                                          // R7
		next_sclk_o     = self_clock & sync_b[0];                              // R7
		next_tx_shift   = tx_shift;
		next_rx_shift   = rx_shift;
		next_rise_count = rise_count;
		next_rx_word    = rx_word;
		next_dout_o     = data_out_o;
		next_dout_oe    = data_out_oe;
		next_din_o      = data_in_o;
		next_din_oe     = data_in_oe;
		if (frame_start) begin
			next_tx_shift   = {result, 4'h0};
			next_dout_o     = result[RES_W-1];
			next_din_o      = result[RES_W-1];
			next_dout_oe    = 1'b1;                                        // R10
			next_rise_count = '0;
		end else if (frame_end) begin
			next_dout_oe = 1'b0;                                           // R10
			next_din_oe  = 1'b0;                                           // R12
			if (rise_count == WORD_BITS) begin
				next_rx_word = rx_shift;
			end
		end else if (frame_on && act_fall) begin
			next_tx_shift = {tx_shift[WORD_W-2:0], 1'b0};
			next_dout_o   = tx_shift[WORD_W-2];
			next_din_o    = tx_shift[WORD_W-2];
		end else if (frame_on && act_rise && rise_count != WORD_BITS) begin
			next_rx_shift   = {rx_shift[WORD_W-2:0], sync_b[6]};
			next_rise_count = rise_count + 5'h01;
			if (readback_en && rise_count == RB_DRIVE_EDGE) begin
				next_din_oe = 1'b1;                                        // R11
			end
			if (rise_count == RB_RELEASE_EDGE) begin
				next_din_oe = 1'b0;                                        // R12
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shift_clock_o  <= 1'b0;
			shift_clock_oe <= 1'b0;
			tx_shift       <= '0;
			rx_shift       <= '0;
			rise_count     <= '0;
			rx_word        <= '0;
			data_out_o     <= 1'b0;
			data_out_oe    <= 1'b0;
			data_in_o      <= 1'b0;
			data_in_oe     <= 1'b0;
		end else begin
			shift_clock_o  <= next_sclk_o;
			shift_clock_oe <= next_sclk_oe;
			tx_shift       <= next_tx_shift;
			rx_shift       <= next_rx_shift;
			rise_count     <= next_rise_count;
			rx_word        <= next_rx_word;
			data_out_o     <= next_dout_o;
			data_out_oe    <= next_dout_oe;
			data_in_o      <= next_din_o;
			data_in_oe     <= next_din_oe;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_conv_bound: assert property (state == SEQ_CONVERT |-> count < CONV_PERIODS && target == CONV_PERIODS) // R1
		else $error("conversion count past its length");
	chk_conv_done: assert property (state == SEQ_CONVERT && seq_done |=> !busy && result_valid) // R1
		else $error("conversion end did not drop busy");
	chk_cal_len: assert property ($rose(state == SEQ_CALIB) && $past(cal_kind) == CAL_FULL |-> target == CAL_FULL_PERIODS) // R2
		else $error("full calibration length wrong");
	chk_cal_dac: assert property ($rose(state == SEQ_CALIB) && $past(cal_kind) == CAL_DAC_FS |-> target == CAL_DAC_FS_PERIODS) // R3
		else $error("dac calibration length wrong");
	chk_cal_offset: assert property ($rose(state == SEQ_CALIB) && $past(cal_kind) == CAL_OFFSET |-> target == CAL_OFFSET_PERIODS) // R4
		else $error("offset calibration length wrong");
	chk_busy_cal: assert property (state == SEQ_IDLE && cal_rise |=> busy ##1 busy) // R5
		else $error("busy late after calibrate request");
	chk_busy_trig: assert property (state == SEQ_IDLE && trig_fall && !cal_rise |=> busy) // R6
		else $error("busy late after trigger fall");
	chk_busy_span: assert property (state inside {SEQ_CONVERT, SEQ_CALIB} |=> busy == !$past(seq_done)) // R16
		else $error("busy wrong at sequence end");
	chk_sw_start: assert property (state == SEQ_IDLE && conv_cmd && !cal_rise && !cal_cmd && !trig_fall |=> state == SEQ_CONVERT) // R15
		else $error("software start ignored");
	chk_self_clock: assert property (self_clock |=> shift_clock_oe && shift_clock_o == $past(sync_b[0])) // R7
		else $error("shift clock not following master clock");
	chk_dout_float: assert property (!frame_on && !frame_start |=> !data_out_oe) // R10
		else $error("serial output driven outside frame");
	chk_din_turn: assert property ($rose(data_in_oe) |-> $past(readback_en && act_rise)) // R11
		else $error("input line turned without rising edge");
endmodule

// ### common/adc_seq_pkg.sv
// Shared constants for the converter sequencing block
package adc_seq_pkg;
	// ---------------------------------------------------------------
	// Register bus
	// ---------------------------------------------------------------
	localparam int          ADDR_W          = 4;
	localparam int          DATA_W          = 32;
	localparam logic [3:0]  OFF_CONTROL     = 4'h0;
	localparam logic [3:0]  OFF_STATUS      = 4'h4;
	localparam logic [3:0]  OFF_RESULT      = 4'h8;
	localparam logic [3:0]  OFF_RX_WORD     = 4'hc;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;

	// Control register fields
	localparam int          CTL_CONV_BIT    = 0;
	localparam int          CTL_KIND_LSB    = 1;
	localparam int          CTL_CAL_BIT     = 3;
	localparam int          CTL_MODE_LSB    = 4;
	localparam int          CTL_READBACK    = 7;
	localparam logic [2:0]  MODE_RESET      = 3'h2;
	// Status register fields
	localparam int          ST_BUSY_BIT     = 0;
	localparam int          ST_CAL_BIT      = 1;
	localparam int          ST_VALID_BIT    = 2;

	// ---------------------------------------------------------------
	// Sequence lengths in master clock periods
	// ---------------------------------------------------------------
	localparam int          CNT_W           = 17;
	localparam logic [16:0] CONV_PERIODS    = 17'h00012;
	localparam logic [16:0] CAL_FULL_DEF    = 17'h1e855;
	localparam logic [16:0] CAL_DAC_FS_DEF  = 17'h1b20a;
	localparam logic [16:0] CAL_OFFSET_DEF  = 17'h0364b;
	localparam real         CAL_FULL_MS     = 31.25;

	// Calibration kinds
	localparam logic [1:0]  CAL_FULL        = 2'h0;
	localparam logic [1:0]  CAL_DAC_FS      = 2'h1;
	localparam logic [1:0]  CAL_OFFSET      = 2'h2;

	// Interface modes with an internally made shift clock
	localparam logic [2:0]  MODE_SELF_A     = 3'h4;
	localparam logic [2:0]  MODE_SELF_B     = 3'h5;

	// ---------------------------------------------------------------
	// Serial frame
	// ---------------------------------------------------------------
	localparam int          RES_W           = 12;
	localparam int          WORD_W          = 16;
	localparam logic [4:0]  WORD_BITS       = 5'h10;
	localparam logic [4:0]  RB_DRIVE_EDGE   = 5'h00;
	localparam logic [4:0]  RB_RELEASE_EDGE = 5'h0f;

	typedef enum logic [1:0] {
		SEQ_IDLE    = 2'b00,
		SEQ_ARMED   = 2'b01,
		SEQ_CONVERT = 2'b10,
		SEQ_CALIB   = 2'b11
	} seq_state_t;
endpackage

// ### test/host_port.sv
// Behavioural host serial port framing words on an external shift clock
`timescale 1ns/1ns
module host_port (
	input  wire logic data_out_o,
	input  wire logic data_out_oe,
	input  wire logic data_in_oe,
	output logic      shift_clock,
	output logic      frame_select_n,
	output logic      din,
	output logic      polarity
);
	// ----------------------------------------------------------
	// Frame engine
	// ----------------------------------------------------------
	logic turned = 1'b0;
	// No frame: clock parked at its idle level
	initial begin
		shift_clock = 1'b1;
		frame_select_n = 1'b1;
		din = 1'b0;
		polarity = 1'b1;
	end
	// One 16-bit frame; 125 ns phases keep the clock at 4 MHz
	task automatic frame(input logic pol, input logic [15:0] tx, output logic [15:0] rx);
		#7;
		polarity = pol;
		shift_clock = pol;
		turned = 1'b0;
		#200 frame_select_n = 1'b0;
		#200;
		for (int i = 15; i >= 0; i--) begin
			rx[i] = data_out_oe ? data_out_o : 1'bx;
			din = tx[i];
			shift_clock = ~pol;
			#60 turned = turned | data_in_oe;
			#65 shift_clock = pol;
			#125;
		end
		frame_select_n = 1'b1;
		din = ~din; // Released line must not keep its last value
		#200;
	endtask
endmodule

// ### test/adc_seq_test.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ns
module adc_seq_test;
	import adc_seq_pkg::*;
	// ----------------------------------------------------------
	// Pins, bus and bookkeeping
	// ----------------------------------------------------------
	logic        aclk = 1'b0, aresetn = 1'b0, mclk = 1'b0, trig = 1'b1, cal = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic [15:0] rx;
	logic [11:0] sample = 12'ha5c;
	wire         awready, wready, bvalid, arready, rvalid, sck_o, sck_oe, din_o, din_oe, dout, dout_oe, busy;
	wire         sck, fs_n, host_din, pol, din_w;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	int          n_errors = 0, compares = 0, n, r;
	int          periods [3] = '{40, 30, 20};
	// Device owns the shared line while turned round
	assign din_w = din_oe ? din_o : host_din;
	// Bus clock 50 MHz; master clock 4 MHz at an unrelated phase
	initial forever #10 aclk = ~aclk;
	initial #3 forever #125 mclk = ~mclk;
	adc_seq #(.CAL_FULL_PERIODS(17'h00028), .CAL_DAC_FS_PERIODS(17'h0001e), .CAL_OFFSET_PERIODS(17'h00014)) dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.master_clock_input(mclk), .conversion_trigger(trig), .cal_request(cal), .polarity(pol),
		.frame_select_n(fs_n), .sample_value(sample), .shift_clock_i(sck), .shift_clock_o(sck_o),
		.shift_clock_oe(sck_oe), .data_in_i(din_w), .data_in_o(din_o), .data_in_oe(din_oe), .data_out_o(dout),
		.data_out_oe(dout_oe), .busy(busy));
	host_port host (.data_out_o(dout), .data_out_oe(dout_oe), .data_in_oe(din_oe), .shift_clock(sck),
		.frame_select_n(fs_n), .din(host_din), .polarity(pol));
	// ----------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	// Write: address and data offered together, each released when taken
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ga, gw;
		ga = 1'b0;
		gw = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ga && gw)) begin
			@(posedge aclk);
			if (!ga && awready === 1'b1) begin
				ga = 1'b1;
				awvalid <= 1'b0;
			end
			if (!gw && wready === 1'b1) begin
				gw = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge aclk);
		chk(bresp, er, "write response");
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge aclk);
		chk(rdata, exp, "read data");
		chk(rresp, er, "read response");
		rready <= 1'b0;
	endtask
	// Start just after a master edge so no edge is lost to the start latency
	task automatic align;
		@(posedge mclk);
		@(posedge aclk);
	endtask
	// Master rising edges seen while busy, and cycle at which busy rose
	task automatic seq(output int n, output int r);
		int c;
		logic mp;
		n = 0;
		r = -1;
		c = 0;
		mp = mclk;
		while (c < 60 || busy === 1'b1) begin
			@(posedge aclk);
			c++;
			if (busy === 1'b1 && r < 0) r = c;
			if (busy === 1'b1 && mclk && !mp) n++;
			mp = mclk;
		end
	endtask
	task automatic complete_run;
		if (n_errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ----------------------------------------------------------
	// Tests
	// ----------------------------------------------------------
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFF_CONTROL, 32'h20, RESP_OKAY);
		rd(OFF_STATUS, 32'h0, RESP_OKAY);
		chk({sck_oe, dout_oe}, 2'b00, "outputs idle");
		wr(OFF_RESULT, 32'h1, RESP_SLVERR);
		align;
		trig <= 1'b0;
		repeat (6) @(posedge aclk);
		chk(busy, 1'b1, "busy after trigger fall");
		repeat (10) @(posedge aclk);
		align;
		trig <= 1'b1;
		seq(n, r);
		chk(n, 18, "conversion length");
		rd(OFF_RESULT, 32'ha5c, RESP_OKAY);
		rd(OFF_STATUS, 32'h4, RESP_OKAY);
		wr(OFF_STATUS, 32'h4, RESP_OKAY);
		rd(OFF_STATUS, 32'h0, RESP_OKAY);
		repeat (25) @(posedge aclk);
		sample <= 12'h3b7;
		align;
		wr(OFF_CONTROL, 32'h21, RESP_OKAY);
		seq(n, r);
		chk(n, 18, "command conversion length");
		rd(OFF_RESULT, 32'h3b7, RESP_OKAY);
		for (int k = 0; k < 3; k++) begin
			wr(OFF_CONTROL, 32'h20 | 32'(k << 1), RESP_OKAY);
			align;
			cal <= 1'b1;
			seq(n, r);
			cal <= 1'b0;
			chk(n, periods[k], "calibration length");
			chk(r <= 30, 1'b1, "busy late after calibrate");
		end
		align;
		wr(OFF_CONTROL, 32'h2c, RESP_OKAY);
		rd(OFF_STATUS, 32'h7, RESP_OKAY);
		seq(n, r);
		chk(n, 20, "command calibration length");
		wr(OFF_CONTROL, 32'h20, RESP_OKAY);
		host.frame(1'b1, 16'hc35a, rx);
		chk(rx, 16'h3b70, "serial word out");
		rd(OFF_RX_WORD, 32'hc35a, RESP_OKAY);
		host.frame(1'b0, 16'h3c96, rx);
		chk(rx, 16'h3b70, "swapped edges word out");
		rd(OFF_RX_WORD, 32'h3c96, RESP_OKAY);
		chk(dout_oe, 1'b0, "serial output released");
		wr(OFF_CONTROL, 32'ha0, RESP_OKAY);
		host.frame(1'b1, 16'hffff, rx);
		chk(host.turned, 1'b1, "readback turnaround");
		chk(din_oe, 1'b0, "readback release");
		wr(OFF_CONTROL, 32'h40, RESP_OKAY);
		repeat (3) begin
			@(posedge mclk);
			repeat (6) @(posedge aclk);
			chk({sck_oe, sck_o}, 2'b11, "self clock high");
			@(negedge mclk);
			repeat (6) @(posedge aclk);
			chk({sck_oe, sck_o}, 2'b10, "self clock low");
		end
		complete_run;
	end
	// Watchdog well beyond the expected run of some 60 us
	initial begin
		#500000;
		n_errors++;
		complete_run;
	end
endmodule
